// ===== rtl/tpwm_regs.svh
// Register offsets, field positions, reset values and timing constants of the PWM timer
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH
// Register word offsets (byte address = 4 * index)
`define TPWM_CTRL1_IDX 4'h0
`define TPWM_CTRL2_IDX 4'h1
`define TPWM_STAT_IDX 4'h2
`define TPWM_CAP1H_IDX 4'h3
`define TPWM_CAP1L_IDX 4'h4
`define TPWM_CMP1H_IDX 4'h5
`define TPWM_CMP1L_IDX 4'h6
`define TPWM_CMP2H_IDX 4'h7
`define TPWM_CMP2L_IDX 4'h8
`define TPWM_CNTH_IDX 4'h9
`define TPWM_CNTL_IDX 4'hA
`define TPWM_ACNTH_IDX 4'hB
`define TPWM_ACNTL_IDX 4'hC
`define TPWM_CAP2H_IDX 4'hD
`define TPWM_CAP2L_IDX 4'hE
// First control register fields
`define TPWM_C1_CIE 7
`define TPWM_C1_MIE 6
`define TPWM_C1_OIE 5
`define TPWM_C1_FL2 4
`define TPWM_C1_FL1 3
`define TPWM_C1_LV2 2
`define TPWM_C1_EDG1 1
`define TPWM_C1_LV1 0
// Second control register fields
`define TPWM_C2_PEN 7
`define TPWM_C2_PEN2 6
`define TPWM_C2_OPM 5
`define TPWM_C2_PWM 4
`define TPWM_C2_CCH 3
`define TPWM_C2_CCL 2
`define TPWM_C2_EDG2 1
`define TPWM_C2_XEDG 0
// Status fields
`define TPWM_S_CF1 7
`define TPWM_S_MF1 6
`define TPWM_S_OVF 5
`define TPWM_S_CF2 4
`define TPWM_S_MF2 3
`define TPWM_S_DIS 2
// Reset and fixed values
`define TPWM_CTRL_RST 8'h00
`define TPWM_CMP_RST 16'h8000
`define TPWM_CNT_RST 16'hFFFC
`define TPWM_PWM_START 16'hFFFC
`define TPWM_CNT_MAX 16'hFFFF
// Tick source codes
`define TPWM_CC_DIV4 2'b00
`define TPWM_CC_DIV2 2'b01
`define TPWM_CC_DIV8 2'b10
`define TPWM_CC_EXT 2'b11
`define TPWM_DIV2_MASK 3'h1
`define TPWM_DIV4_MASK 3'h3
`define TPWM_DIV8_MASK 3'h7
`endif

// ===== rtl/tpwm_pkg.sv
// Types shared by the PWM timer
`default_nettype none
package tpwm_pkg;
   typedef enum logic [1:0] {
      TPWM_RUN = 2'b00,
      TPWM_WAIT = 2'b01,
      TPWM_HALT = 2'b11
   } tpwm_pwr_t;
   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic dis;
      logic [15:0] cnt;
      logic [15:0] acnt;
      logic [2:0] pre;
      logic [15:0] cmp1_act;
      logic [15:0] cmp2_act;
      logic [15:0] cmp1_buf;
      logic [15:0] cmp2_buf;
      logic [7:0] hi_tmp;
      logic cmp1_inh;
      logic cmp2_inh;
      logic [15:0] cap1;
      logic [15:0] cap2;
      logic cf1;
      logic cf2;
      logic mf1;
      logic mf2;
      logic ovf;
      logic [4:0] stat_seen;
      logic arm1;
      logic arm2;
      logic cap1_d;
      logic cap2_d;
      logic ext_d;
      logic out_lvl;
      tpwm_pwr_t pwr;
      logic [31:0] rdata;
      logic rvalid;
   } tpwm_state_t;
endpackage
`default_nettype wire

// ===== rtl/tpwm_timer.sv
// 16-bit timer with PWM waveform mode, low-power behaviour and shared interrupt
`default_nettype none
`include "tpwm_regs.svh"
module tpwm_timer #(
   parameter bit REDUCED = 1'b0,
   parameter bit HAS_EXT_CLK = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic capture_pin_one,
   input wire logic capture_pin_two,
   input wire logic ext_tick_pin,
   input wire logic irq_masked,
   input wire logic wait_req,
   input wire logic halt_req,
   input wire logic halt_wake_irq,
   output logic wave_out_pin,
   output logic wave_out_pin_oe_b,
   output logic timer_irq,
   output logic wake_from_wait
);
   tpwm_pkg::tpwm_state_t s_q, s_d;
   logic [3:0] idx;
   logic acc, rd, wr, pwm_on, tick, running, m1, m2, e1, e2, ext_edge;
   logic [7:0] rbyte;
   logic [4:0] irq_src;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode: word index, one-cycle waitrequest gives registered read data
   // Writes land only at the edge where waitrequest is low, so a held request never writes early
   assign idx = avs_address[5:2];
   assign acc = (avs_read | avs_write) & ~s_q.rvalid;
   assign rd = avs_read & ~s_q.rvalid;
   assign wr = avs_write & avs_byteenable[0] & s_q.rvalid;
   assign avs_waitrequest = (avs_read | avs_write) & ~s_q.rvalid;
   assign avs_readdata = s_q.rdata;

   // Mode, tick and match terms
   assign pwm_on = s_q.ctrl2[`TPWM_C2_PWM];
   assign running = (s_q.pwr != tpwm_pkg::TPWM_HALT) & ~s_q.dis;
   assign ext_edge = s_q.ctrl2[`TPWM_C2_XEDG] ? (ext_tick_pin & ~s_q.ext_d) : (~ext_tick_pin & s_q.ext_d);
   always_comb begin
      unique case (s_q.ctrl2[`TPWM_C2_CCH:`TPWM_C2_CCL])
         `TPWM_CC_DIV4: tick = s_q.pre[1:0] == `TPWM_DIV4_MASK;
         `TPWM_CC_DIV2: tick = s_q.pre[0] == `TPWM_DIV2_MASK;
         `TPWM_CC_DIV8: tick = s_q.pre == `TPWM_DIV8_MASK;
         `TPWM_CC_EXT: tick = HAS_EXT_CLK & ext_edge;
      endcase
   end
   assign m1 = tick & running & ~s_q.cmp1_inh & (s_q.cnt == s_q.cmp1_act);
   assign m2 = tick & running & ~s_q.cmp2_inh & (s_q.cnt == s_q.cmp2_act);
   // Capture edges; pin one is cut off in PWM mode
   assign e1 = ~pwm_on & (s_q.ctrl1[`TPWM_C1_EDG1] ? (capture_pin_one & ~s_q.cap1_d) :
               (~capture_pin_one & s_q.cap1_d));
   assign e2 = ~REDUCED & (s_q.ctrl2[`TPWM_C2_EDG2] ? (capture_pin_two & ~s_q.cap2_d) :
               (~capture_pin_two & s_q.cap2_d));

   ////////////////////////////////////////////////////////////////////////////
   // Shared interrupt line and wait wake-up
   assign irq_src = {s_q.cf1 & s_q.ctrl1[`TPWM_C1_CIE], s_q.cf2 & s_q.ctrl1[`TPWM_C1_CIE],
                     s_q.mf1 & s_q.ctrl1[`TPWM_C1_MIE], s_q.mf2 & s_q.ctrl1[`TPWM_C1_MIE],
                     s_q.ovf & s_q.ctrl1[`TPWM_C1_OIE]};
   assign timer_irq = (|irq_src) & ~irq_masked;
   assign wake_from_wait = timer_irq & (s_q.pwr == tpwm_pkg::TPWM_WAIT);
   assign wave_out_pin = s_q.out_lvl;
   assign wave_out_pin_oe_b = ~(s_q.ctrl2[`TPWM_C2_PEN] & ~s_q.dis);

   ////////////////////////////////////////////////////////////////////////////
   // Read mux of byte registers
   always_comb begin
      rbyte = 8'h00;
      unique case (idx)
         `TPWM_CTRL1_IDX: rbyte = s_q.ctrl1;
         `TPWM_CTRL2_IDX: rbyte = s_q.ctrl2;
         `TPWM_STAT_IDX: rbyte = {s_q.cf1, s_q.mf1, s_q.ovf, s_q.cf2, s_q.mf2, s_q.dis, 2'b00};
         `TPWM_CAP1H_IDX: rbyte = s_q.cap1[15:8];
         `TPWM_CAP1L_IDX: rbyte = s_q.cap1[7:0];
         `TPWM_CMP1H_IDX: rbyte = s_q.cmp1_buf[15:8];
         `TPWM_CMP1L_IDX: rbyte = s_q.cmp1_buf[7:0];
         `TPWM_CMP2H_IDX: rbyte = REDUCED ? 8'h00 : s_q.cmp2_buf[15:8];
         `TPWM_CMP2L_IDX: rbyte = REDUCED ? 8'h00 : s_q.cmp2_buf[7:0];
         `TPWM_CNTH_IDX: rbyte = s_q.cnt[15:8];
         `TPWM_CNTL_IDX: rbyte = s_q.cnt[7:0];
         `TPWM_ACNTH_IDX: rbyte = s_q.acnt[15:8];
         `TPWM_ACNTL_IDX: rbyte = s_q.acnt[7:0];
         `TPWM_CAP2H_IDX: rbyte = REDUCED ? 8'h00 : s_q.cap2[15:8];
         `TPWM_CAP2L_IDX: rbyte = REDUCED ? 8'h00 : s_q.cap2[7:0];
         default: rbyte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.rvalid = acc;
      s_d.rdata = rd ? {24'h00_0000, rbyte} : 32'h0000_0000;
      s_d.cap1_d = capture_pin_one;
      s_d.cap2_d = capture_pin_two;
      s_d.ext_d = ext_tick_pin;
      // Power state follows the core's requests
      if (halt_req) begin
         s_d.pwr = tpwm_pkg::TPWM_HALT;
      end else if (wait_req) begin
         s_d.pwr = tpwm_pkg::TPWM_WAIT;
      end else begin
         s_d.pwr = tpwm_pkg::TPWM_RUN;
      end
      // Prescaler frozen in halt or when disabled
      if (running) begin
         s_d.pre = s_q.pre + 3'h1;
      end
      // Counter: PWM reload on match two, else increment with wrap
      if (tick & running) begin
         s_d.cnt = s_q.cnt + 16'h0001;
         s_d.acnt = s_q.acnt + 16'h0001;
      end
      // Flag clear: status read marks armed flags, low-byte access clears them
      if (rd && idx == `TPWM_STAT_IDX) begin
         s_d.stat_seen = {s_q.cf1, s_q.mf1, s_q.ovf, s_q.cf2, s_q.mf2};
      end
      if (acc && idx == `TPWM_CAP1L_IDX && s_q.stat_seen[4]) begin
         s_d.cf1 = 1'b0;
         s_d.stat_seen[4] = 1'b0;
      end
      if (acc && idx == `TPWM_CMP1L_IDX && s_q.stat_seen[3]) begin
         s_d.mf1 = 1'b0;
         s_d.stat_seen[3] = 1'b0;
      end
      if (acc && idx == `TPWM_CNTL_IDX && s_q.stat_seen[2]) begin
         s_d.ovf = 1'b0;
         s_d.stat_seen[2] = 1'b0;
      end
      if (acc && idx == `TPWM_CAP2L_IDX && s_q.stat_seen[1]) begin
         s_d.cf2 = 1'b0;
         s_d.stat_seen[1] = 1'b0;
      end
      if (acc && idx == `TPWM_CMP2L_IDX && s_q.stat_seen[0]) begin
         s_d.mf2 = 1'b0;
         s_d.stat_seen[0] = 1'b0;
      end
      // Overflow set follows the clears so a same-cycle set wins
      if (tick && running && s_q.cnt == `TPWM_CNT_MAX && !pwm_on) begin
         s_d.ovf = 1'b1;
      end
      // Register writes; compare high byte inhibits until low byte lands
      if (wr) begin
         unique case (idx)
            `TPWM_CTRL1_IDX: s_d.ctrl1 = avs_writedata[7:0];
            `TPWM_CTRL2_IDX: s_d.ctrl2 = avs_writedata[7:0];
            `TPWM_STAT_IDX: s_d.dis = avs_writedata[`TPWM_S_DIS];
            `TPWM_CMP1H_IDX: begin
               s_d.cmp1_buf[15:8] = avs_writedata[7:0];
               s_d.cmp1_inh = 1'b1;
            end
            `TPWM_CMP1L_IDX: begin
               s_d.cmp1_buf[7:0] = avs_writedata[7:0];
               s_d.cmp1_inh = 1'b0;
            end
            `TPWM_CMP2H_IDX: begin
               s_d.cmp2_buf[15:8] = avs_writedata[7:0];
               s_d.cmp2_inh = 1'b1;
            end
            `TPWM_CMP2L_IDX: begin
               s_d.cmp2_buf[7:0] = avs_writedata[7:0];
               s_d.cmp2_inh = 1'b0;
            end
            `TPWM_CNTL_IDX: s_d.cnt = `TPWM_CNT_RST;
            `TPWM_ACNTL_IDX: s_d.acnt = `TPWM_CNT_RST;
            default: s_d.hi_tmp = s_q.hi_tmp;
         endcase
      end
      // Outside PWM the compare values are used as soon as written
      if (!pwm_on) begin
         s_d.cmp1_act = s_d.cmp1_buf;
         s_d.cmp2_act = s_d.cmp2_buf;
      end
      // Waveform generation
      if (pwm_on) begin
         if (m1) begin
            s_d.out_lvl = s_q.ctrl1[`TPWM_C1_LV1];
         end
         if (m2) begin
            s_d.out_lvl = s_q.ctrl1[`TPWM_C1_LV2];
            s_d.cnt = `TPWM_PWM_START;
            s_d.acnt = `TPWM_PWM_START;
            s_d.cmp1_act = s_q.cmp1_buf;
            s_d.cmp2_act = s_q.cmp2_buf;
            s_d.cf1 = 1'b1;
         end
      end else begin
         // Plain compare channels only outside PWM; single pulse is not built here
         if (m1) begin
            s_d.mf1 = 1'b1;
            if (s_q.ctrl2[`TPWM_C2_PEN]) begin
               s_d.out_lvl = s_q.ctrl1[`TPWM_C1_LV1];
            end
         end
         if (m2 && !REDUCED) begin
            s_d.mf2 = 1'b1;
         end
         if (s_q.ctrl1[`TPWM_C1_FL1]) begin
            s_d.out_lvl = s_q.ctrl1[`TPWM_C1_LV1];
         end
      end
      // Captures; in halt an edge only arms, wake-up completes it
      if (s_q.pwr == tpwm_pkg::TPWM_HALT) begin
         if (e1) begin
            s_d.arm1 = 1'b1;
         end
         if (e2) begin
            s_d.arm2 = 1'b1;
         end
         if (halt_wake_irq) begin
            s_d.pwr = tpwm_pkg::TPWM_RUN;
            if (s_q.arm1 | e1) begin
               s_d.cf1 = 1'b1;
               s_d.cap1 = s_q.cnt;
            end
            if (s_q.arm2 | e2) begin
               s_d.cf2 = 1'b1;
               s_d.cap2 = s_q.cnt;
            end
            s_d.arm1 = 1'b0;
            s_d.arm2 = 1'b0;
         end
      end else begin
         if (e1) begin
            s_d.cf1 = 1'b1;
            s_d.cap1 = s_q.cnt;
         end
         if (e2) begin
            s_d.cf2 = 1'b1;
            s_d.cap2 = s_q.cnt;
         end
      end
      if (REDUCED) begin
         s_d.cf2 = 1'b0;
         s_d.mf2 = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset restarts the counter from its reset value
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.ctrl1 <= `TPWM_CTRL_RST;
         s_q.ctrl2 <= `TPWM_CTRL_RST;
         s_q.cnt <= `TPWM_CNT_RST;
         s_q.acnt <= `TPWM_CNT_RST;
         s_q.cmp1_buf <= `TPWM_CMP_RST;
         s_q.cmp2_buf <= `TPWM_CMP_RST;
         s_q.cmp1_act <= `TPWM_CMP_RST;
         s_q.cmp2_act <= `TPWM_CMP_RST;
         // Edge detectors start at the pin level so no false edge follows reset
         s_q.cap1_d <= capture_pin_one;
         s_q.cap2_d <= capture_pin_two;
         s_q.ext_d <= ext_tick_pin;
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/tpwm_timer_properties.sv
// Port-level checks on the PWM timer
`default_nettype none
module tpwm_timer_checker (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq_masked,
   input wire logic wait_req,
   input wire logic halt_req,
   input wire logic halt_wake_irq,
   input wire logic wave_out_pin,
   input wire logic wave_out_pin_oe_b,
   input wire logic timer_irq,
   input wire logic wake_from_wait
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   // Steps of one bus access: a waited first cycle, then the answer
   sequence s_req_waiting;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answered;
      !avs_waitrequest;
   endsequence
   chk_one_wait: assert property (s_req_waiting |=> s_answered) else $error("bus answer late");
   chk_wait_start: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
      else $error("first request cycle not waited");
   chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait raised without request");
   chk_read_quiet: assert property ((!avs_read || avs_waitrequest) |-> avs_readdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
   chk_upper_zero: assert property (avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
   ////////////////////////////////////////////////////////////////////////////////
   // Pin, interrupt and power behaviour
   chk_reset_quiet: assert property ($rose(rst_b) |-> wave_out_pin_oe_b && !wave_out_pin && !timer_irq)
      else $error("pin or interrupt active after reset");
   chk_irq_masked: assert property (irq_masked |-> !timer_irq)
      else $error("interrupt while masked");
   chk_wake_cause: assert property (wake_from_wait |-> timer_irq && $past(wait_req))
      else $error("wake without interrupt");
   chk_wait_wake: assert property ((timer_irq && $past(rst_b) && $past(wait_req) && !$past(halt_req)
      && !$past(halt_wake_irq)) |-> wake_from_wait) else $error("enabled interrupt did not wake from wait");
   chk_halt_freeze: assert property ((halt_req && !halt_wake_irq) [*3] |-> $stable(wave_out_pin))
      else $error("pin moved in halt");
endmodule
bind tpwm_timer tpwm_timer_checker i_tpwm_timer_checker (.ref_clk, .rst_b, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .irq_masked, .wait_req, .halt_req, .halt_wake_irq, .wave_out_pin, .wave_out_pin_oe_b, .timer_irq,
   .wake_from_wait);
`default_nettype wire

// ===== testbench/tpwm_pin_load.sv
// Pin load model that times the waveform in reference clock cycles
`default_nettype none
module tpwm_pin_load (
   input wire logic ref_clk,
   input wire logic wave_out_pin,
   input wire logic wave_out_pin_oe_b,
   output var logic [15:0] high_len = 16'h0000,
   output var logic [15:0] period_len = 16'h0000,
   output var logic [15:0] rise_cnt = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ns;
   logic level_q = 1'b0;
   logic [15:0] since_rise_q = 16'h0000;
   logic level;
   // Undriven pin falls to the load's pull-down, never holds the last value
   assign level = wave_out_pin_oe_b ? 1'b0 : wave_out_pin;
   // Rise to rise gives the period, rise to fall the high span
   always @(posedge ref_clk) begin
      level_q <= level;
      since_rise_q <= since_rise_q + 16'h0001;
      if (level && !level_q) begin
         period_len <= since_rise_q;
         since_rise_q <= 16'h0001;
         rise_cnt <= rise_cnt + 16'h0001;
      end
      if (!level && level_q) high_len <= since_rise_q;
   end
endmodule
`default_nettype wire

// ===== testbench/tpwm_timer_tb.sv
// Self-checking bench for the PWM timer
`default_nettype none
`include "tpwm_regs.svh"
module tpwm_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic ext_tick_pin = 1'b0;
   logic irq_masked = 1'b0;
   logic wait_req = 1'b0;
   logic halt_req = 1'b0;
   logic halt_wake_irq = 1'b0;
   logic capture_pin_one = 1'b0;
   logic capture_pin_two = 1'b0;
   logic wave_out_pin, wave_out_pin_oe_b, timer_irq, wake_from_wait;
   logic [15:0] high_len, period_len, rise_cnt, rc;
   logic [7:0] rd;
   logic [7:0] c1;
   logic [15:0] held;
   logic [1:0] ext_div = 2'h0;
   logic [1:0] codes[4] = '{2'b00, 2'b10, 2'b11, 2'b01};
   int divs[4] = '{4, 8, 6, 2};
   int num_errors = 0;
   int tests_run = 0;
   always #50 ref_clk = ~ref_clk;
   // External tick pin toggles every three cycles: one falling edge per six
   always @(posedge ref_clk) begin
      ext_div <= (ext_div == 2'h2) ? 2'h0 : ext_div + 2'h1;
      if (ext_div == 2'h2) ext_tick_pin <= ~ext_tick_pin;
   end
   tpwm_timer i_tpwm_timer (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .capture_pin_one, .capture_pin_two, .ext_tick_pin, .irq_masked,
      .wait_req, .halt_req, .halt_wake_irq, .wave_out_pin, .wave_out_pin_oe_b, .timer_irq, .wake_from_wait);
   tpwm_pin_load i_tpwm_pin_load (.ref_clk, .wave_out_pin, .wave_out_pin_oe_b, .high_len, .period_len, .rise_cnt);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One access held until waitrequest is sampled low; only the watchdog ends a wait
   task automatic xfer(input bit is_wr, input logic [3:0] idx, input logic [7:0] wd);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h00_0000, wd};
      avs_read <= !is_wr;
      avs_write <= is_wr;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask
   task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      check({8'h00, rd}, {8'h00, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      cyc(8);
      rst_b <= 1'b1;
      rdchk(`TPWM_CTRL1_IDX, 8'h00);
      rdchk(`TPWM_CMP1H_IDX, 8'h80);
      rdchk(4'hF, 8'h00);
      wr(`TPWM_CTRL1_IDX, 8'h81);
      rdchk(`TPWM_CTRL1_IDX, 8'h81);
      // A write without the low byte lane is ignored
      avs_byteenable <= 4'h0;
      wr(`TPWM_CTRL1_IDX, 8'hFF);
      avs_byteenable <= 4'h1;
      rdchk(`TPWM_CTRL1_IDX, 8'h81);
      // Period 21 ticks, written as ticks minus five; high 8 ticks, the gap from compare one to compare two
      wr(`TPWM_CMP2H_IDX, 8'h00);
      wr(`TPWM_CMP2L_IDX, 8'h10);
      wr(`TPWM_CMP1H_IDX, 8'h00);
      wr(`TPWM_CMP1L_IDX, 8'h08);
      // Every tick source, with single pulse also selected so waveform must win
      for (int i = 0; i < 4; i++) begin
         wr(`TPWM_CTRL2_IDX, {4'hB, codes[i], 2'b00});
         wr(`TPWM_CNTL_IDX, 8'h00);
         cyc(63 * divs[i] + 40);
         check(period_len, 16'(21 * divs[i]));
         check(high_len, 16'(8 * divs[i]));
      end
      check({15'h0000, wave_out_pin_oe_b}, 16'h0000);
      // Period end raises capture flag one; compare flags stay clear
      xfer(1'b0, `TPWM_STAT_IDX, 8'h00);
      check({8'h00, rd & 8'hD8}, 16'h0080);
      check({15'h0000, timer_irq}, 16'h0001);
      irq_masked <= 1'b1;
      cyc(2);
      check({15'h0000, timer_irq}, 16'h0000);
      irq_masked <= 1'b0;
      // Wait leaves the timer running and reports the pending wake
      wait_req <= 1'b1;
      cyc(150);
      check({15'h0000, wake_from_wait}, 16'h0001);
      check(period_len, 16'h002A);
      wait_req <= 1'b0;
      // Halt stops waveform and counter; a capture two edge only arms until an interrupt wake, pin one is cut off in PWM
      halt_req <= 1'b1;
      cyc(4);
      rc = rise_cnt;
      xfer(1'b0, `TPWM_CAP1L_IDX, 8'h00);
      c1 = rd;
      check({15'h0000, timer_irq}, 16'h0000);
      capture_pin_one <= 1'b1;
      capture_pin_two <= 1'b1;
      cyc(2);
      capture_pin_one <= 1'b0;
      capture_pin_two <= 1'b0;
      cyc(2);
      xfer(1'b0, `TPWM_CNTH_IDX, 8'h00);
      held[15:8] = rd;
      xfer(1'b0, `TPWM_CNTL_IDX, 8'h00);
      held[7:0] = rd;
      xfer(1'b0, `TPWM_STAT_IDX, 8'h00);
      check({8'h00, rd & 8'h10}, 16'h0000);
      cyc(100);
      check(rise_cnt, rc);
      halt_wake_irq <= 1'b1;
      halt_req <= 1'b0;
      cyc(1);
      halt_wake_irq <= 1'b0;
      cyc(100);
      check({15'h0000, rise_cnt != rc}, 16'h0001);
      // The wake completes the armed capture with the count held in halt
      xfer(1'b0, `TPWM_STAT_IDX, 8'h00);
      check({8'h00, rd & 8'h10}, 16'h0010);
      rdchk(`TPWM_CAP2H_IDX, held[15:8]);
      rdchk(`TPWM_CAP2L_IDX, held[7:0]);
      rdchk(`TPWM_CAP1L_IDX, c1);
      // A lone high byte write holds off compare two; the low byte brings a new period
      rc = rise_cnt;
      wr(`TPWM_CMP2H_IDX, 8'h00);
      cyc(200);
      check({15'h0000, (rise_cnt - rc) <= 16'h0002}, 16'h0001);
      wr(`TPWM_CMP2L_IDX, 8'h20);
      wr(`TPWM_CNTL_IDX, 8'h00);
      cyc(300);
      check(period_len, 16'h004A);
      check(high_len, 16'h0030);
      // Equal levels hold the pin steady
      wr(`TPWM_CTRL1_IDX, 8'h85);
      cyc(100);
      rc = rise_cnt;
      cyc(200);
      check(rise_cnt, rc);
      check({15'h0000, wave_out_pin}, 16'h0001);
      finish_test();
   end
   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
